/* File: dct_host.sv */
`timescale 1ns/1ns
`default_nettype none
module dct_host (
    // clock
    input wire logic ref_clk,
    // write side
    output var logic [7:0] s_axi_awaddr,
    output var logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output var logic [31:0] s_axi_wdata,
    output var logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output var logic s_axi_bready,
    // read side
    output var logic [7:0] s_axi_araddr,
    output var logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output var logic s_axi_rready
);
    logic slow;
    initial begin
        slow = 0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
        s_axi_wdata = 32'h0;
    end
    // released payload shows the inverse, never the last value
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge ref_clk);
        {s_axi_awvalid, s_axi_awaddr} <= {1'b1, a};
        {s_axi_wvalid, s_axi_wdata} <= {1'b1, d};
        s_axi_bready <= !slow;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
            if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
            if (s_axi_bvalid) s_axi_bready <= 1;
        end while (!(s_axi_bvalid && s_axi_bready));
        r = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge ref_clk);
        {s_axi_arvalid, s_axi_araddr} <= {1'b1, a};
        s_axi_rready <= !slow;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
            if (s_axi_rvalid) s_axi_rready <= 1;
        end while (!(s_axi_rvalid && s_axi_rready));
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
endmodule // dct_host
`default_nettype wire

/* File: dct_map.vh */
`ifndef DCT_MAP_VH
`define DCT_MAP_VH
// byte addresses of the registers
`define DCT_ADDR_NCOND 8'h9c
`define DCT_ADDR_PCW 8'ha0
`define DCT_ADDR_PMOD 8'ha4
`define DCT_ADDR_TMODE 8'ha8
`define DCT_ADDR_CTRL 8'hb0
`define DCT_ADDR_IRQSTAT 8'hb4
`define DCT_ADDR_IRQMASK 8'hb8
`define DCT_ADDR_STAT 8'hbc
// register indexes as printed
`define DCT_IDX_NCOND 8'h27
`define DCT_IDX_PCW 8'h28
`define DCT_IDX_PMOD 8'h29
`define DCT_IDX_TMODE 8'h2a
// reset values
`define DCT_RST_NCOND 8'h88
`define DCT_RST_PCW 6'h20
`define DCT_RST_PMOD 6'h20
`define DCT_RST_TMODE 8'h00
// timer mode fields
`define DCT_TM_AUTO 7
`define DCT_TM_GATE_HI 6
`define DCT_TM_GATE_LO 5
`define DCT_TM_RELOAD 4
`define DCT_TM_PRE_HI 3
// gate select codes
`define DCT_GATE_NONE 2'h0
`define DCT_GATE_FIRST 2'h1
`define DCT_GATE_AUX 2'h2
// control register bits
`define DCT_CTRL_PDOWN 0
`define DCT_CTRL_FULLASK 1
`define DCT_CTRL_DRV1 2
`define DCT_CTRL_DRV2 3
`define DCT_CTRL_PRELO 15
`define DCT_CTRL_PRELO_LO 8
`define DCT_CTRL_MASK 32'h0000ff0f
// interrupt bits
`define DCT_IRQ_START 0
`define DCT_IRQ_EXPIRE 1
`define DCT_IRQ_RELOAD 2
`define DCT_IRQ_W 3
// axi responses
`define DCT_RESP_OKAY 2'h0
`define DCT_RESP_SLVERR 2'h2
`endif

/* File: dct_regs.v */
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "dct_map.vh"

module dct_regs (
    // clock and reset
    input wire ref_clk,
    input wire reset_n,
    // axi4-lite write
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // timer events and gate pins
    input wire txDone,
    input wire timerAtEnd,
    input wire firstGateInput,
    input wire auxiliaryGateInput,
    // driver settings
    output reg [3:0] carrierNConductance,
    output reg [3:0] modulationNConductance,
    output reg [5:0] carrierPConductance,
    output reg [5:0] modulationPConductance,
    output reg modulationPEnable,
    output reg antennaDriveOne,
    output reg antennaDriveTwo,
    // timer control
    output reg [11:0] prescaleValue,
    output reg timerStart,
    output reg timerReload,
    output reg timerStop,
    output reg timerGateOpen,
    output reg irq
);

    reg [7:0] nCond_r;
    reg [5:0] pCw_r;
    reg [5:0] pMod_r;
    reg [7:0] tMode_r;
    reg [15:0] ctrl_r;
    reg [2:0] irqStat_r;
    reg [2:0] irqMask_r;
    reg [7:0] awAddr_r;
    reg [31:0] wData_r;
    reg [3:0] wStrb_r;
    reg awHave_r;
    reg wHave_r;
    reg timerRunning_r;

    wire pdown = ctrl_r[`DCT_CTRL_PDOWN];
    wire driveOn = ctrl_r[`DCT_CTRL_DRV1] | ctrl_r[`DCT_CTRL_DRV2];
    wire doWrite = awHave_r & wHave_r & ~s_axi_bvalid;
    wire [1:0] gateSel = tMode_r[`DCT_TM_GATE_HI:`DCT_TM_GATE_LO];
    wire startEv = tMode_r[`DCT_TM_AUTO] & txDone;
    wire endEv = timerAtEnd & timerRunning_r;
    wire reloadEv = endEv & tMode_r[`DCT_TM_RELOAD];
    wire expireEv = endEv & ~tMode_r[`DCT_TM_RELOAD];
    wire [2:0] irqEv = {reloadEv, expireEv, startEv};

    // forces the top bit of a field in power-down
    function [5:0] forceTop;
        input [5:0] val;
        input integer w;
        input f;
        begin
            forceTop = val;
            if (f) begin
                forceTop[w-1] = 1'b1;
            end
        end
    endfunction

    // merges byte lanes of a write into the old word
    function [31:0] laneMerge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer i;
        begin
            laneMerge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    laneMerge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    wire [31:0] wM = laneMerge(32'h0, wData_r, wStrb_r);
    // control word, reserved bits cleared
    wire [31:0] ctrlMerged = laneMerge({16'h0, ctrl_r}, wData_r,
        wStrb_r) & `DCT_CTRL_MASK;
    // n-driver fields with power-down forcing
    wire [5:0] nCarForced = forceTop({2'b00, nCond_r[7:4]}, 4, pdown);
    wire [5:0] nModForced = forceTop({2'b00, nCond_r[3:0]}, 4, pdown);

    // write channel
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DCT_RESP_OKAY;
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r <= 32'h0;
            wStrb_r <= 4'h0;
            nCond_r <= `DCT_RST_NCOND;
            pCw_r <= `DCT_RST_PCW;
            pMod_r <= `DCT_RST_PMOD;
            tMode_r <= `DCT_RST_TMODE;
            ctrl_r <= 16'h0;
            irqMask_r <= 3'h0;
            irqStat_r <= 3'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_r <= s_axi_awaddr;
                awHave_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
                wHave_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            irqStat_r <= irqStat_r | irqEv;
            if (doWrite) begin
                awHave_r <= 1'b0;
                wHave_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `DCT_RESP_OKAY;
                case ({awAddr_r[7:2], 2'b00})
                    `DCT_ADDR_NCOND: begin
                        if (wStrb_r[0]) nCond_r <= wData_r[7:0];
                    end
                    `DCT_ADDR_PCW: begin
                        if (wStrb_r[0]) pCw_r <= wData_r[5:0];
                    end
                    `DCT_ADDR_PMOD: begin
                        if (wStrb_r[0]) pMod_r <= wData_r[5:0];
                    end
                    `DCT_ADDR_TMODE: begin
                        if (wStrb_r[0]) tMode_r <= wData_r[7:0];
                    end
                    `DCT_ADDR_CTRL: begin
                        ctrl_r <= ctrlMerged[15:0];
                    end
                    `DCT_ADDR_IRQSTAT: begin
                        // set wins over write-one-to-clear
                        irqStat_r <= (irqStat_r & ~wM[2:0]) | irqEv;
                    end
                    `DCT_ADDR_IRQMASK: begin
                        if (wStrb_r[0]) irqMask_r <= wData_r[2:0];
                    end
                    `DCT_ADDR_STAT: begin
                        s_axi_bresp <= `DCT_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `DCT_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read channel
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `DCT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `DCT_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                `DCT_ADDR_NCOND: s_axi_rdata <= {24'h0, nCond_r};
                `DCT_ADDR_PCW: s_axi_rdata <= {26'h0, pCw_r};
                `DCT_ADDR_PMOD: s_axi_rdata <= {26'h0, pMod_r};
                `DCT_ADDR_TMODE: s_axi_rdata <= {24'h0, tMode_r};
                `DCT_ADDR_CTRL: s_axi_rdata <= {16'h0, ctrl_r};
                `DCT_ADDR_IRQSTAT: s_axi_rdata <= {29'h0, irqStat_r};
                `DCT_ADDR_IRQMASK: s_axi_rdata <= {29'h0, irqMask_r};
                `DCT_ADDR_STAT: s_axi_rdata <= {30'h0, timerGateOpen,
                    timerRunning_r};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `DCT_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // driver and timer outputs
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            carrierNConductance <= 4'h0;
            modulationNConductance <= 4'h0;
            carrierPConductance <= 6'h0;
            modulationPConductance <= 6'h0;
            modulationPEnable <= 1'b0;
            antennaDriveOne <= 1'b0;
            antennaDriveTwo <= 1'b0;
            prescaleValue <= 12'h000;
            timerStart <= 1'b0;
            timerReload <= 1'b0;
            timerStop <= 1'b0;
            timerGateOpen <= 1'b0;
            timerRunning_r <= 1'b0;
            irq <= 1'b0;
        end else begin
            antennaDriveOne <= ctrl_r[`DCT_CTRL_DRV1];
            antennaDriveTwo <= ctrl_r[`DCT_CTRL_DRV2];
            // binary-weighted fields pass unscaled
            if (driveOn) begin
                carrierNConductance <= nCarForced[3:0];
                modulationNConductance <= nModForced[3:0];
            end else begin
                carrierNConductance <= 4'h0;
                modulationNConductance <= 4'h0;
            end
            carrierPConductance <= forceTop(pCw_r, 6, pdown);
            modulationPConductance <= forceTop(pMod_r, 6, pdown);
            modulationPEnable <= ~ctrl_r[`DCT_CTRL_FULLASK];
            prescaleValue <= {tMode_r[`DCT_TM_PRE_HI:0],
                ctrl_r[`DCT_CTRL_PRELO:`DCT_CTRL_PRELO_LO]};
            case (gateSel)
                `DCT_GATE_NONE: timerGateOpen <= 1'b1;
                `DCT_GATE_FIRST: timerGateOpen <= firstGateInput;
                `DCT_GATE_AUX: timerGateOpen <= auxiliaryGateInput;
                default: timerGateOpen <= 1'b0;
            endcase
            timerStart <= startEv;
            timerReload <= reloadEv;
            timerStop <= expireEv;
            if (startEv) begin
                timerRunning_r <= 1'b1;
            end else if (expireEv) begin
                timerRunning_r <= 1'b0;
            end
            irq <= |(irqStat_r & irqMask_r);
        end
    end

endmodule // dct_regs
`default_nettype wire

/* File: dct_regs_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module dct_regs_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // timer and drivers
    input wire logic txDone,
    input wire logic timerAtEnd,
    input wire logic timerStart,
    input wire logic timerReload,
    input wire logic timerStop,
    input wire logic antennaDriveOne,
    input wire logic antennaDriveTwo,
    input wire logic [3:0] carrierNConductance,
    input wire logic [3:0] modulationNConductance
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    property p_bdue;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> ##1 s_axi_bvalid;
    endproperty
    a_bdue: assert property (p_bdue) else $error("write answer late");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    property p_rdue; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rdue: assert property (p_rdue) else $error("read answer late");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    a_rhold: assert property (p_rhold) else $error("rvalid dropped");
    property p_start; timerStart |-> $past(txDone); endproperty
    a_start: assert property (p_start) else $error("start without cause");
    property p_end; timerReload || timerStop |-> $past(timerAtEnd); endproperty
    a_end: assert property (p_end) else $error("end pulse without cause");
    property p_excl; !(timerReload && timerStop); endproperty
    a_excl: assert property (p_excl) else $error("reload and stop together");
    property p_drvoff;
        !antennaDriveOne && !antennaDriveTwo
            |-> {carrierNConductance, modulationNConductance} == 8'h00;
    endproperty
    a_drvoff: assert property (p_drvoff) else $error("conductance while off");
endmodule // dct_regs_monitor
bind dct_regs dct_regs_monitor mon (.*);
`default_nettype wire

/* File: dct_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module dct_regs_tb;
logic ref_clk, reset_n, txDone, timerAtEnd, firstGateInput, auxiliaryGateInput;
logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
logic modulationPEnable, antennaDriveOne, antennaDriveTwo, timerStart;
logic timerReload, timerStop, timerGateOpen, irq;
logic [7:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic [3:0] carrierNConductance, modulationNConductance;
logic [5:0] carrierPConductance, modulationPConductance;
logic [11:0] prescaleValue;
wire logic [3:0] s_axi_wstrb = 4'hf;
int failures = 0;
int cmp_count = 0;
dct_regs dut (.*);
dct_host host (.*);
initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
end
task summarize;
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    summarize;
end
task automatic chk(input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
        failures++;
        $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    host.wr(a, d, r);
    chk({30'h0, r}, 32'h0);
endtask
task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    chk(d, e);
endtask
task w3;
    repeat (3) @(posedge ref_clk);
    #1;
endtask
// one-cycle event pulse: 0 end of transmission, 1 end of count
task ev(input logic s);
    w3;
    {txDone, timerAtEnd} <= {!s, s};
    @(posedge ref_clk);
    {txDone, timerAtEnd} <= 2'h0;
    #1;
endtask
initial begin
    logic [31:0] d;
    logic [1:0] r;
    {reset_n, txDone, timerAtEnd, firstGateInput, auxiliaryGateInput} = 5'h0;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1;
    rc(8'h9c, 32'h88);
    rc(8'ha0, 32'h20);
    rc(8'ha4, 32'h20);
    rc(8'ha8, 32'h00);
    wr(8'ha0, 32'hff);
    rc(8'ha0, 32'h3f);
    host.slow = 1;
    wr(8'ha8, 32'ha5);
    rc(8'ha8, 32'ha5);
    host.slow = 0;
    host.rd(8'hc0, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, 32'h2);
    host.wr(8'hc4, 32'h1, r);
    chk({30'h0, r}, 32'h2);
    wr(8'hb0, 32'h5a0c);
    wr(8'h9c, 32'h35);
    wr(8'ha0, 32'h15);
    wr(8'ha4, 32'h0a);
    w3;
    chk(32'(prescaleValue), 32'h55a);
    chk(32'({carrierNConductance, modulationNConductance}), 32'h35);
    chk(32'({carrierPConductance, modulationPConductance}), 32'h54a);
    chk(32'(modulationPEnable), 32'h1);
    chk(32'({antennaDriveOne, antennaDriveTwo}), 32'h3);
    wr(8'hb0, 32'h0f);
    w3;
    chk(32'({carrierNConductance, modulationNConductance}), 32'hbd);
    chk(32'({carrierPConductance, modulationPConductance}), 32'hd6a);
    chk(32'(modulationPEnable), 32'h0);
    wr(8'hb0, 32'h00);
    w3;
    chk(32'({carrierNConductance, modulationNConductance}), 32'h0);
    for (int g = 0; g < 4; g++) begin
        wr(8'ha8, 32'(g) << 5);
        for (int p = 0; p < 2; p++) begin
            firstGateInput <= p[0];
            auxiliaryGateInput <= !p[0];
            w3;
            chk(32'(timerGateOpen), 32'(g == 0 || g == 1 && p == 1 || g == 2 && p == 0));
        end
    end
    wr(8'ha8, 32'h80);
    ev(0);
    chk(32'(timerStart), 32'h1);
    ev(1);
    chk(32'({timerReload, timerStop}), 32'h1);
    wr(8'ha8, 32'h90);
    ev(0);
    ev(1);
    chk(32'({timerReload, timerStop}), 32'h2);
    wr(8'ha8, 32'h00);
    ev(0);
    chk(32'(timerStart), 32'h0);
    w3;
    chk(32'(irq), 32'h0);
    wr(8'hb8, 32'h2);
    w3;
    chk(32'(irq), 32'h1);
    wr(8'hb4, 32'h2);
    w3;
    chk(32'(irq), 32'h0);
    rc(8'hb4, 32'h5);
    rc(8'hbc, 32'h3);
    summarize;
end
endmodule // dct_regs_tb
`default_nettype wire
